// ===== core/tpp_consts.vh
// constants of the three-phase pwm block: offsets, fields, timing
// assumes a 200 MHz sys_clk and a plain strobe register port
// How it works
// - undivided triangle carrier, period 3240, 2.0us dead time
// - new duties load at carrier trough, and on every cycle while not running
// - adc start trigger every period, never skipped
// - all six gate outputs are active high
// - falling edge on overcurrent input requests stop
// - both gates of a phase on forces stop
// - stop interrupt level 15, no nesting
// - adc done interrupt level 12, nestable
// - u on b b/d, v on b a/c, w on a b/d
// - adc trigger fires one clock after the carrier trough
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH

`define TPP_CNT_W        12
`define TPP_PERIOD       12'hCA8
`define TPP_CARRIER_NS   50000
`define TPP_CLK_NS       5
`define TPP_DEAD_NS      2000
`define TPP_DEAD_CYC     ((`TPP_DEAD_NS + `TPP_CLK_NS - 1) / `TPP_CLK_NS)
`define TPP_DT_W         10

`define TPP_ADDR_W       8
`define TPP_DATA_W       32
`define TPP_OFS_CTRL     8'h00
`define TPP_OFS_DUTY_U   8'h04
`define TPP_OFS_DUTY_V   8'h08
`define TPP_OFS_DUTY_W   8'h0C
`define TPP_OFS_STAT     8'h10
`define TPP_OFS_MASK     8'h14
`define TPP_OFS_STATE    8'h18

`define TPP_CTRL_RUN     0
`define TPP_CTRL_CLR     1
`define TPP_EV_W         3
`define TPP_EV_STOP      0
`define TPP_EV_SHORT     1
`define TPP_EV_ADC       2
`define TPP_ST_LATCH     0
`define TPP_ST_UP        1
`define TPP_ST_CNT_LO    4

`define TPP_LVL_STOP     4'hF
`define TPP_LVL_ADC      4'hC
`define TPP_LVL_NONE     4'h0

`endif

// ===== core/tpp_phase.v
// one complementary gate pair with dead-time insertion
// assumes carrier count and duty are stable in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.vh"
module tpp_phase (
  input  wire                  sys_clk,
  input  wire                  sys_rst,
  input  wire                  en,
  input  wire [`TPP_CNT_W-1:0] cnt,
  input  wire [`TPP_CNT_W-1:0] duty,
  output reg                   hi_r,
  output reg                   lo_r
);
  // dead time rounded up to whole clocks, never shorter than asked
  localparam integer         DT_I    = `TPP_DEAD_CYC;
  localparam [`TPP_DT_W-1:0] DT      = DT_I[`TPP_DT_W-1:0];
  localparam [`TPP_DT_W-1:0] DT_ZERO = {`TPP_DT_W{1'b0}};

  wire                 want_hi;
  reg                  side_r;
  reg [`TPP_DT_W-1:0]  dt_r;

  assign want_hi = (cnt < duty);

  // every change of side waits the full dead time with both gates off
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      side_r <= 1'b0;
      dt_r   <= DT;
      hi_r   <= 1'b0;
      lo_r   <= 1'b0;
    end else if (!en) begin
      side_r <= 1'b0;
      dt_r   <= DT;
      hi_r   <= 1'b0;
      lo_r   <= 1'b0;
    end else if (want_hi != side_r) begin
      side_r <= want_hi;
      dt_r   <= DT;
      hi_r   <= 1'b0;
      lo_r   <= 1'b0;
    end else if (dt_r != DT_ZERO) begin
      dt_r   <= dt_r - 1'b1;
      hi_r   <= 1'b0;
      lo_r   <= 1'b0;
    end else begin
      hi_r   <= side_r;
      lo_r   <= ~side_r;
    end
  end
endmodule
`default_nettype wire

// ===== core/tpp_top.v
// three-phase complementary pwm with emergency stop and adc trigger
// assumes synchronous pins and a one-cycle strobe register port
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.vh"
module tpp_top (
  input  wire                  sys_clk,
  input  wire                  sys_rst,
  input  wire [`TPP_ADDR_W-1:0] reg_addr,
  input  wire [`TPP_DATA_W-1:0] reg_wdata,
  input  wire                  reg_we,
  input  wire                  reg_re,
  output reg  [`TPP_DATA_W-1:0] reg_rdata,
  input  wire                  overcurrent_stop_input_n,
  input  wire                  adc_done,
  output reg                   adc_start,
  output reg                   ch_b_out_b,
  output reg                   ch_b_out_d,
  output reg                   ch_b_out_a,
  output reg                   ch_b_out_c,
  output reg                   ch_a_out_b,
  output reg                   ch_a_out_d,
  output reg                   irq,
  output reg  [3:0]            irq_level,
  output reg                   irq_nest_ok
);
  localparam [`TPP_CNT_W-1:0] PER     = `TPP_PERIOD;
  localparam [`TPP_CNT_W-1:0] CNT_ONE = {{(`TPP_CNT_W-1){1'b0}}, 1'b1};
  // turn one step early so the peak itself is the period value
  localparam [`TPP_CNT_W-1:0] CNT_TOP = PER - CNT_ONE;

  // counter direction state, one-hot
  localparam [1:0] ST_UP   = 2'b01;
  localparam [1:0] ST_DOWN = 2'b10;

  reg                   run_r;
  reg                   run_nxt;
  reg [1:0]             dir_r;
  reg [1:0]             dir_nxt;
  reg [`TPP_CNT_W-1:0]  cnt_r;
  reg [`TPP_CNT_W-1:0]  cnt_nxt;
  reg [`TPP_CNT_W-1:0]  shd_u_r;
  reg [`TPP_CNT_W-1:0]  shd_v_r;
  reg [`TPP_CNT_W-1:0]  shd_w_r;
  reg [`TPP_CNT_W-1:0]  act_u_r;
  reg [`TPP_CNT_W-1:0]  act_v_r;
  reg [`TPP_CNT_W-1:0]  act_w_r;
  reg                   oc_prev_r;
  reg                   latch_r;
  reg                   latch_nxt;
  reg [`TPP_EV_W-1:0]   stat_r;
  reg [`TPP_EV_W-1:0]   stat_nxt;
  reg [`TPP_EV_W-1:0]   mask_r;
  reg [`TPP_DATA_W-1:0] rd_nxt;

  wire                  trough;
  wire                  oc_fall;
  wire                  shorted;
  wire                  gate_en;
  wire                  wr_ctrl;
  wire                  rd_stat;
  wire [`TPP_EV_W-1:0]  events;
  wire [`TPP_EV_W-1:0]  pend;
  wire                  u_hi;
  wire                  u_lo;
  wire                  v_hi;
  wire                  v_lo;
  wire                  w_hi;
  wire                  w_lo;

  assign trough  = run_r && (cnt_r == {`TPP_CNT_W{1'b0}});
  assign oc_fall = oc_prev_r && !overcurrent_stop_input_n;
  // duty compare and dead time may never overlap, but guard anyway
  assign shorted = (u_hi & u_lo) | (v_hi & v_lo) | (w_hi & w_lo);
  assign gate_en = run_r && !latch_r;
  assign wr_ctrl = reg_we && (reg_addr == `TPP_OFS_CTRL);
  assign rd_stat = reg_re && (reg_addr == `TPP_OFS_STAT);
  assign pend    = stat_r & mask_r;

  assign events[`TPP_EV_STOP]  = oc_fall;
  assign events[`TPP_EV_SHORT] = shorted;
  assign events[`TPP_EV_ADC]   = adc_done;

  // ---------------- carrier counter
  always @* begin
    run_nxt = run_r;
    if (wr_ctrl) begin
      run_nxt = reg_wdata[`TPP_CTRL_RUN];
    end
  end

  // triangle: 0 up to period, back down to 0; the trough is count zero
  always @* begin
    dir_nxt = dir_r;
    cnt_nxt = cnt_r;
    if (!run_r) begin
      dir_nxt = ST_UP;
      cnt_nxt = {`TPP_CNT_W{1'b0}};
    end else begin
      case (dir_r)
        ST_UP: begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == CNT_TOP) begin
            dir_nxt = ST_DOWN;
          end
        end
        ST_DOWN: begin
          cnt_nxt = cnt_r - CNT_ONE;
          if (cnt_r == CNT_ONE) begin
            dir_nxt = ST_UP;
          end
        end
        default: begin
          dir_nxt = ST_UP;
          cnt_nxt = {`TPP_CNT_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      dir_r <= ST_UP;
      cnt_r <= {`TPP_CNT_W{1'b0}};
    end else begin
      run_r <= run_nxt;
      dir_r <= dir_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------- duty shadow and active copies
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shd_u_r <= {`TPP_CNT_W{1'b0}};
      shd_v_r <= {`TPP_CNT_W{1'b0}};
      shd_w_r <= {`TPP_CNT_W{1'b0}};
    end else if (reg_we) begin
      if (reg_addr == `TPP_OFS_DUTY_U) begin
        shd_u_r <= reg_wdata[`TPP_CNT_W-1:0];
      end
      if (reg_addr == `TPP_OFS_DUTY_V) begin
        shd_v_r <= reg_wdata[`TPP_CNT_W-1:0];
      end
      if (reg_addr == `TPP_OFS_DUTY_W) begin
        shd_w_r <= reg_wdata[`TPP_CNT_W-1:0];
      end
    end
  end

  // load while idle too, so the first period starts with fresh duties
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_u_r <= {`TPP_CNT_W{1'b0}};
      act_v_r <= {`TPP_CNT_W{1'b0}};
      act_w_r <= {`TPP_CNT_W{1'b0}};
    end else if (trough || !run_r) begin
      act_u_r <= shd_u_r;
      act_v_r <= shd_v_r;
      act_w_r <= shd_w_r;
    end
  end

  // ---------------- adc trigger, one pulse per carrier period
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= trough;
    end
  end

  // ---------------- phases
  tpp_phase u_ph_u (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .en      (gate_en),
    .cnt     (cnt_r),
    .duty    (act_u_r),
    .hi_r    (u_hi),
    .lo_r    (u_lo)
  );

  tpp_phase u_ph_v (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .en      (gate_en),
    .cnt     (cnt_r),
    .duty    (act_v_r),
    .hi_r    (v_hi),
    .lo_r    (v_lo)
  );

  tpp_phase u_ph_w (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .en      (gate_en),
    .cnt     (cnt_r),
    .duty    (act_w_r),
    .hi_r    (w_hi),
    .lo_r    (w_lo)
  );

  // ---------------- emergency stop latch
  // a new stop event beats a simultaneous software clear
  always @* begin
    latch_nxt = latch_r;
    if (wr_ctrl && reg_wdata[`TPP_CTRL_CLR]) begin
      latch_nxt = 1'b0;
    end
    if (oc_fall || shorted) begin
      latch_nxt = 1'b1;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oc_prev_r <= 1'b1;
      latch_r   <= 1'b0;
    end else begin
      oc_prev_r <= overcurrent_stop_input_n;
      latch_r   <= latch_nxt;
    end
  end

  // ---------------- gate pins, killed combinationally from the event
  // so the pins drop on the same edge that latches the stop
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch_b_out_b <= 1'b0;
      ch_b_out_d <= 1'b0;
      ch_b_out_a <= 1'b0;
      ch_b_out_c <= 1'b0;
      ch_a_out_b <= 1'b0;
      ch_a_out_d <= 1'b0;
    end else if (latch_nxt) begin
      ch_b_out_b <= 1'b0;
      ch_b_out_d <= 1'b0;
      ch_b_out_a <= 1'b0;
      ch_b_out_c <= 1'b0;
      ch_a_out_b <= 1'b0;
      ch_a_out_d <= 1'b0;
    end else begin
      ch_b_out_b <= u_hi;
      ch_b_out_d <= u_lo;
      ch_b_out_a <= v_hi;
      ch_b_out_c <= v_lo;
      ch_a_out_b <= w_hi;
      ch_a_out_d <= w_lo;
    end
  end

  // ---------------- status, mask, interrupt
  // read of status clears it; a same-cycle event survives the clear
  always @* begin
    stat_nxt = stat_r;
    if (rd_stat) begin
      stat_nxt = {`TPP_EV_W{1'b0}};
    end
    stat_nxt = stat_nxt | events;
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= {`TPP_EV_W{1'b0}};
      mask_r <= {`TPP_EV_W{1'b0}};
    end else begin
      stat_r <= stat_nxt;
      if (reg_we && (reg_addr == `TPP_OFS_MASK)) begin
        mask_r <= reg_wdata[`TPP_EV_W-1:0];
      end
    end
  end

  // stop and short share the top level; adc completion sits below
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq         <= 1'b0;
      irq_level   <= `TPP_LVL_NONE;
      irq_nest_ok <= 1'b0;
    end else begin
      irq <= |(stat_nxt & mask_r);
      if (|(stat_nxt[`TPP_EV_SHORT:`TPP_EV_STOP]
            & mask_r[`TPP_EV_SHORT:`TPP_EV_STOP])) begin
        irq_level   <= `TPP_LVL_STOP;
        irq_nest_ok <= 1'b0;
      end else if (stat_nxt[`TPP_EV_ADC] & mask_r[`TPP_EV_ADC]) begin
        irq_level   <= `TPP_LVL_ADC;
        irq_nest_ok <= 1'b1;
      end else begin
        irq_level   <= `TPP_LVL_NONE;
        irq_nest_ok <= 1'b0;
      end
    end
  end

  // ---------------- read port, data one cycle after the strobe
  always @* begin
    rd_nxt = {`TPP_DATA_W{1'b0}};
    case (reg_addr)
      `TPP_OFS_CTRL: begin
        rd_nxt[`TPP_CTRL_RUN] = run_r;
      end
      `TPP_OFS_DUTY_U: begin
        rd_nxt[`TPP_CNT_W-1:0] = shd_u_r;
      end
      `TPP_OFS_DUTY_V: begin
        rd_nxt[`TPP_CNT_W-1:0] = shd_v_r;
      end
      `TPP_OFS_DUTY_W: begin
        rd_nxt[`TPP_CNT_W-1:0] = shd_w_r;
      end
      `TPP_OFS_STAT: begin
        rd_nxt[`TPP_EV_W-1:0] = stat_r;
      end
      `TPP_OFS_MASK: begin
        rd_nxt[`TPP_EV_W-1:0] = mask_r;
      end
      `TPP_OFS_STATE: begin
        rd_nxt[`TPP_ST_LATCH] = latch_r;
        rd_nxt[`TPP_ST_UP]    = dir_r[0];
        rd_nxt[`TPP_ST_CNT_LO+`TPP_CNT_W-1:`TPP_ST_CNT_LO] = cnt_r;
      end
      default: begin
        rd_nxt = {`TPP_DATA_W{1'b0}};
      end
    endcase
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= {`TPP_DATA_W{1'b0}};
    end else if (reg_re) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= {`TPP_DATA_W{1'b0}};
    end
  end
endmodule
`default_nettype wire

// ===== test/three_phase_pwm_with_emergency_stop_tb.sv
// bench for the pwm block: registers, carrier, stop and interrupts
// assumes tpp_top and the far-side model; reads checked through a queue
`timescale 1ns/1ps
`default_nettype none
module three_phase_pwm_with_emergency_stop_tb;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic        trip = 1'b0;
  logic        adc_en = 1'b0;
  logic [7:0]  adc_lat = 8'h00;
  logic        rd_pend = 1'b0;
  wire  [31:0] reg_rdata;
  wire         oc_n, adc_done, adc_start, irq, nest;
  wire  [3:0]  lvl;
  wire  [5:0]  g;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          bad_count = 0;
  int          checks_done = 0;
  int          d[3];
  int          e[3];
  int          c[7];
  tpp_top tpp_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata),
    .overcurrent_stop_input_n(oc_n), .adc_done(adc_done),
    .adc_start(adc_start), .ch_b_out_b(g[0]), .ch_b_out_d(g[1]),
    .ch_b_out_a(g[2]), .ch_b_out_c(g[3]), .ch_a_out_b(g[4]),
    .ch_a_out_d(g[5]), .irq(irq), .irq_level(lvl), .irq_nest_ok(nest));
  tpp_far_model tpp_far_model_inst (.sys_clk(sys_clk), .trip(trip),
    .adc_en(adc_en), .adc_start(adc_start), .adc_lat(adc_lat),
    .oc_n(oc_n), .adc_done(adc_done));
  always #2.5 sys_clk = ~sys_clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // counts near the trough move by a cycle or two with pipeline lag
  task automatic chk_near(input int got, input int exp);
    checks_done++;
    if (got < exp - 3 || got > exp + 3) begin
      bad_count++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_pend && exp_q.size() > 0)
      chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    rd_pend <= reg_re;
  end
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] v, input logic [31:0] m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= w;
    reg_re <= !w;
    if (!w) begin
      exp_q.push_back(v);
      msk_q.push_back(m);
    end
    @(posedge sys_clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
  endtask
  task automatic waitfor(input logic sel);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((sel ? irq : adc_start) !== 1'b1 && n < 7000);
    if (n >= 7000) begin
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test;
    end
  endtask
  task automatic duties;
    for (int i = 0; i < 3; i++) begin
      d[i] = 500 + $urandom_range(2000);
      bus(1'b1, 8'h04 + 8'(4 * i), d[i], 32'h0);
    end
  endtask
  // gate-on cycles of each pin over one trough-to-trough window
  task automatic window;
    c = '{0, 0, 0, 0, 0, 0, 0};
    waitfor(1'b0);
    do begin
      @(posedge sys_clk);
      c[0] += g[0];
      c[1] += g[2];
      c[2] += g[4];
      c[3]++;
      c[4] += g[1];
      c[5] += g[3];
      c[6] += g[5];
    end while (adc_start !== 1'b1 && c[3] < 7000);
    if (c[3] >= 7000) begin
      bad_count++;
      $display("[ERR] %0t window ran out", $time);
      end_of_test;
    end
  endtask
  task automatic chk_win(input int x[3]);
    chk(c[3], 32'd6480);
    for (int i = 0; i < 3; i++) begin
      chk_near(c[i], 2 * x[i] - 401);
      chk_near(c[4 + i], 6081 - 2 * x[i]);
    end
  endtask
  initial begin
    d[0] = $urandom(32'hD732);
    adc_lat = 8'($urandom_range(40));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 8'h14, 32'h7, 32'h0);
    bus(1'b0, 8'h14, 32'h7, 32'hFFFFFFFF);
    bus(1'b1, 8'h40, 32'hFFFFFFFF, 32'h0);
    bus(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
    duties;
    bus(1'b0, 8'h04, d[0], 32'hFFFFFFFF);
    bus(1'b1, 8'h00, 32'h1, 32'h0);
    $display("registers done");
    // first period opens inside a dead time, so skip it
    waitfor(1'b0);
    window;
    chk_win(d);
    e = d;
    fork
      window;
      begin
        // writes land mid-window; they must wait for the next trough
        waitfor(1'b0);
        repeat (3000) @(posedge sys_clk);
        duties;
      end
    join
    chk_win(e);
    window;
    chk_win(d);
    $display("carrier done");
    trip <= 1'b1;
    repeat (4) @(posedge sys_clk);
    repeat (40) begin
      @(posedge sys_clk);
      chk({26'h0, g}, 32'h0);
    end
    chk({26'h0, irq, nest, lvl}, 32'h2F);
    bus(1'b0, 8'h10, 32'h1, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
    trip <= 1'b0;
    repeat (50) @(posedge sys_clk);
    chk({26'h0, g}, 32'h0);
    bus(1'b0, 8'h18, 32'h1, 32'h1);
    bus(1'b1, 8'h00, 32'h3, 32'h0);
    bus(1'b0, 8'h18, 32'h0, 32'h1);
    window;
    chk_win(d);
    $display("stop done");
    bus(1'b1, 8'h14, 32'h3, 32'h0);
    adc_en <= 1'b1;
    waitfor(1'b0);
    repeat (100) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h10, 32'h4, 32'hFFFFFFFF);
    bus(1'b1, 8'h14, 32'h7, 32'h0);
    waitfor(1'b1);
    chk({26'h0, irq, nest, lvl}, 32'h3C);
    bus(1'b0, 8'h10, 32'h4, 32'hFFFFFFFF);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    $display("interrupts done");
    end_of_test;
  end
endmodule
`default_nettype wire

// ===== test/tpp_far_model.sv
// far side of the pwm block: overcurrent detector and a/d converter
// assumes the bench commands trips and picks the conversion delay
`timescale 1ns/1ps
`default_nettype none
module tpp_far_model (
  input  wire logic       sys_clk,
  input  wire logic       trip,
  input  wire logic       adc_en,
  input  wire logic       adc_start,
  input  wire logic [7:0] adc_lat,
  output var  logic       oc_n,
  output var  logic       adc_done
);
  logic [7:0] wait_r = 8'h00;
  logic       busy_r = 1'b0;
  initial oc_n = 1'b1;
  initial adc_done = 1'b0;
  // detector pulls the stop line low while overcurrent lasts
  always @(posedge sys_clk) oc_n <= ~trip;
  // converter answers each start after adc_lat + 1 cycles, one-cycle pulse
  always @(posedge sys_clk) begin
    adc_done <= 1'b0;
    if (adc_start && adc_en) begin
      busy_r <= 1'b1;
      wait_r <= adc_lat;
    end else if (busy_r && wait_r == 8'h00) begin
      busy_r <= 1'b0;
      adc_done <= 1'b1;
    end else if (busy_r) begin
      wait_r <= wait_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/tpp_props.sv
// checker for tpp_top: gate safety, stop, trigger and interrupt timing
// assumes it is bound to tpp_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tpp_props (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic        overcurrent_stop_input_n,
  input wire logic        adc_start,
  input wire logic        ch_b_out_b,
  input wire logic        ch_b_out_d,
  input wire logic        ch_b_out_a,
  input wire logic        ch_b_out_c,
  input wire logic        ch_a_out_b,
  input wire logic        ch_a_out_d,
  input wire logic        irq,
  input wire logic [3:0]  irq_level,
  input wire logic        irq_nest_ok
);
  logic [5:0]  gates;
  logic [15:0] gap_r;
  logic [15:0] u_off_r;
  assign gates = {ch_b_out_b, ch_b_out_d, ch_b_out_a, ch_b_out_c,
                  ch_a_out_b, ch_a_out_d};
  // saturating; reset to full so the first event is not judged
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= 16'hFFFF;
      u_off_r <= 16'hFFFF;
    end else begin
      gap_r <= adc_start ? 16'h0000 : gap_r + {15'h0, gap_r != 16'hFFFF};
      u_off_r <= (ch_b_out_b | ch_b_out_d) ? 16'h0000
               : u_off_r + {15'h0, u_off_r != 16'hFFFF};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  stop_gates_off_a: assert property (
    $fell(overcurrent_stop_input_n) |-> ##2 (gates == 6'h00) [*8])
    else $error("gates still driven after overcurrent stop");
  stop_level_a: assert property (
    $fell(overcurrent_stop_input_n) ##2 irq |-> irq_level == 4'hF
    && !irq_nest_ok) else $error("stop interrupt level wrong");
  irq_level_a: assert property (
    irq |-> (irq_level == 4'hF && !irq_nest_ok)
    || (irq_level == 4'hC && irq_nest_ok))
    else $error("interrupt level and nesting disagree");
  adc_pulse_a: assert property (
    adc_start |=> !adc_start) else $error("trigger longer than a cycle");
  adc_gap_a: assert property (
    adc_start |-> gap_r >= 16'd6479) else $error("carrier period short");
  dead_u_a: assert property (
    $rose(ch_b_out_b) || $rose(ch_b_out_d) |-> u_off_r >= 16'd399)
    else $error("dead time too short on u pair");
  no_short_a: assert property (
    !(ch_b_out_b && ch_b_out_d) && !(ch_b_out_a && ch_b_out_c)
    && !(ch_a_out_b && ch_a_out_d)) else $error("both gates of a pair on");
  rdata_idle_a: assert property (
    !reg_re |=> reg_rdata == 32'h0) else $error("read data without read");
  cover property ($fell(overcurrent_stop_input_n));
  cover property (adc_start);
  cover property (irq && irq_level == 4'hC);
endmodule
bind tpp_top tpp_props tpp_props_inst (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .overcurrent_stop_input_n(overcurrent_stop_input_n),
  .adc_start(adc_start), .ch_b_out_b(ch_b_out_b), .ch_b_out_d(ch_b_out_d),
  .ch_b_out_a(ch_b_out_a), .ch_b_out_c(ch_b_out_c),
  .ch_a_out_b(ch_a_out_b), .ch_a_out_d(ch_a_out_d), .irq(irq),
  .irq_level(irq_level), .irq_nest_ok(irq_nest_ok));
`default_nettype wire
